//--- efr_readout.sv
`timescale 1ns/1ns
`default_nettype none
`include "efr_map.svh"
module efr_readout #(
    parameter int unsigned IN_TMO_CYC = `EFR_IN_TMO_MS * (`EFR_NS_PER_MS / `EFR_CLK_NS),
    parameter int unsigned MS_CYC = `EFR_NS_PER_MS / `EFR_CLK_NS,
    parameter int unsigned RECOV_CYC = `EFR_RECOV_US * `EFR_NS_PER_US / `EFR_CLK_NS
) (
    input wire logic clk_i, // System clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic [7:0] rx_byte_i, // Received serial byte
    input wire logic rx_valid_i, // Received byte strobe
    input wire logic rx_frame_err_i, // Stop bit missing
    input wire logic rx_overrun_i, // Receiver overrun
    input wire logic rx_drop_i, // Byte queue full, byte lost
    input wire logic crc_en_i, // Check byte required
    input wire logic [6:0] dev_num_i, // Own device number
    input wire logic tmo_en_i, // Serial timeout enabled
    input wire logic [15:0] tmo_ms_i, // Serial timeout in ms
    input wire efr_pkg::efr_inmode_e input_mode_i, // Input source
    input wire logic [11:0] analog_in_i, // Analog input conversion
    input wire logic aux_in_en_i, // Input open test enabled
    input wire logic aux_in_open_i, // Input found open
    input wire logic [11:0] in_max_i, // Input absolute maximum
    input wire logic [11:0] in_min_i, // Input absolute minimum
    input wire logic pulse_done_i, // Pulse measured
    input wire logic pulse_good_i, // Pulse valid
    input wire logic [11:0] pulse_width_i, // Pulse width
    input wire logic fb_analog_i, // Analog feedback mode
    input wire logic [11:0] fb_i, // Raw feedback
    input wire logic aux_fb_en_i, // Feedback open test enabled
    input wire logic aux_fb_open_i, // Feedback found open
    input wire logic [11:0] fb_max_i, // Feedback absolute maximum
    input wire logic [11:0] fb_min_i, // Feedback absolute minimum
    input wire logic [15:0] scaled_fb_i, // Scaled feedback
    input wire logic [15:0] err_sum_i, // Error sum
    input wire logic [15:0] duty_tgt_i, // Duty cycle target
    input wire logic [15:0] duty_i, // Duty cycle
    input wire logic [7:0] current_i, // Motor current
    input wire logic [7:0] current_max_i, // Current limit
    input wire logic [15:0] pid_count_i, // Loop period count
    input wire logic drv_fault_i, // Motor driver fault
    input wire logic usb_i, // USB attached
    input wire logic motor_pwr_i, // Motor power present
    input wire efr_pkg::efr_word_t err_en_i, // Error enables
    input wire logic tx_ready_i, // Transmitter takes byte
    output logic [7:0] tx_byte_o, // Response byte
    output logic tx_valid_o, // Response byte valid
    output logic [11:0] target_o, // Target value
    output logic err_line_o, // Error line
    output logic red_led_o, // Red indicator
    output logic drv_toggle_o // Driver recovery line
);
    import efr_pkg::*;

    efr_state_e st;
    logic [7:0] cmd;
    logic [6:0] dat;
    logic [7:0] crc;
    logic [7:0] crc_nx;
    logic [7:0] cmd_in;
    logic [1:0] len;
    logic opening;
    logic interrupted;
    logic go;
    logic crc_bad;
    logic proto_bad;
    efr_word_t halt;
    efr_word_t occ;
    efr_word_t ev;
    efr_word_t en_eff;
    efr_word_t halt_clr;
    logic [11:0] in_val;
    logic [11:0] pw_val;
    logic pw_invalid;
    logic por_done;
    logic [31:0] ms_cnt;
    logic [15:0] tmo_ms;
    logic [31:0] rec_cnt;
    logic is_halt;
    logic is_occ;
    logic motor_off;
    logic set_tgt;
    logic rd_go;
    logic tx_free;
    logic pend;
    logic [7:0] pend_byte;
    logic [7:0] off8;
    logic [3:0] idx;
    logic two;
    efr_word_t var_val;
    logic [7:0] resp_lo;
    logic [7:0] resp_hi;

    // Byte-wise CRC-7, bits taken LSB first as they travel on the line
    function automatic logic [7:0] crc_step(input logic [7:0] acc, input logic [7:0] b);
        logic [7:0] c;
        c = acc ^ b;
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c ^ `EFR_CRC_POLY) >> 1) : (c >> 1);
        end
        return c;
    endfunction : crc_step

    // Data bytes following a command byte; bad length marks unknown codes
    function automatic logic [1:0] cmd_len(input logic [7:0] c);
        if (c[7:5] == `EFR_C_HIRES || c == `EFR_C_FWD || c == `EFR_C_REV) begin
            return 2'h1;
        end
        if (c == `EFR_C_OFF || (c >= `EFR_C_RD_LO && c <= `EFR_C_RD_HI)) begin
            return 2'h0;
        end
        return `EFR_LEN_BAD;
    endfunction : cmd_len

    // ****************************************************************
    // Packet parser
    // ****************************************************************

    // Addressed form carries the command with its top bit cleared
    assign cmd_in = (st == ST_ACMD) ? (rx_byte_i | `EFR_CMD_MSB) : rx_byte_i;
    assign len = cmd_len(cmd_in);
    assign crc_nx = crc_step(rx_byte_i[7] ? 8'h00 : crc, rx_byte_i);
    assign opening = rx_valid_i && ((rx_byte_i[7] && rx_byte_i != `EFR_C_START)
                     || (!rx_byte_i[7] && st == ST_ACMD));
    assign interrupted = rx_valid_i && rx_byte_i[7] && st != ST_IDLE && st != ST_SKIP;

    // Sequence the packet bytes; a new command byte always restarts
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= ST_IDLE;
            cmd <= 8'h00;
            dat <= 7'h00;
            crc <= 8'h00;
            go <= 1'b0;
            crc_bad <= 1'b0;
            proto_bad <= 1'b0;
        end else begin
            go <= 1'b0;
            crc_bad <= 1'b0;
            proto_bad <= interrupted || (opening && len == `EFR_LEN_BAD);
            if (opening) begin
                cmd <= cmd_in;
                crc <= crc_nx;
                case (len)
                    2'h0: begin
                        st <= crc_en_i ? ST_CRC : ST_IDLE;
                        go <= !crc_en_i;
                    end
                    2'h1: st <= ST_DATA;
                    default: st <= ST_IDLE;
                endcase
            end else if (rx_valid_i && rx_byte_i == `EFR_C_START) begin
                crc <= crc_nx;
                st <= ST_ADDR;
            end else if (rx_valid_i && rx_byte_i[7]) begin
                st <= ST_IDLE;
            end else if (rx_valid_i) begin
                case (st)
                    ST_ADDR: begin
                        crc <= crc_nx;
                        st <= (rx_byte_i[6:0] == dev_num_i) ? ST_ACMD : ST_SKIP;
                    end
                    ST_DATA: begin
                        dat <= rx_byte_i[6:0];
                        crc <= crc_nx;
                        st <= crc_en_i ? ST_CRC : ST_IDLE;
                        go <= !crc_en_i;
                    end
                    ST_CRC: begin
                        st <= ST_IDLE;
                        go <= (rx_byte_i == crc);
                        crc_bad <= (rx_byte_i != crc);
                    end
                    default: st <= st;
                endcase
            end
        end
    end

    // ****************************************************************
    // Command execution and variables
    // ****************************************************************

    assign is_halt = (cmd == `EFR_C_HALT);
    assign is_occ = (cmd == `EFR_C_OCC);
    assign motor_off = go && (cmd == `EFR_C_OFF || (cmd == `EFR_C_REV && dat == 7'h00));
    assign set_tgt = go && (cmd[7:5] == `EFR_C_HIRES || cmd == `EFR_C_FWD
                     || (cmd == `EFR_C_REV && dat != 7'h00));
    assign rd_go = go && cmd >= `EFR_C_RD_LO && cmd <= `EFR_C_RD_HI;

    // Target only moves in serial input mode
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            target_o <= `EFR_TGT_MID;
        end else if (set_tgt && input_mode_i == IN_SERIAL) begin
            if (cmd == `EFR_C_FWD) begin
                target_o <= `EFR_TGT_MID + {1'b0, dat, 4'h0};
            end else if (cmd == `EFR_C_REV) begin
                target_o <= `EFR_TGT_MID - {1'b0, dat, 4'h0};
            end else begin
                target_o <= {dat, cmd[4:0]};
            end
        end
    end

    efr_pulse_in #(
        .TMO_CYC(IN_TMO_CYC)
    ) u_pulse (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(input_mode_i == IN_PULSE),
        .pulse_done_i(pulse_done_i),
        .pulse_good_i(pulse_good_i),
        .pulse_width_i(pulse_width_i),
        .value_o(pw_val),
        .invalid_o(pw_invalid)
    );

    // Input variable by source
    always_comb begin
        case (input_mode_i)
            IN_SERIAL: in_val = target_o;
            IN_PULSE: in_val = pw_val;
            default: in_val = analog_in_i;
        endcase
    end

    // Read code to variable index and byte choice
    always_comb begin
        two = (cmd >= `EFR_C_TWO_LO);
        off8 = cmd - (two ? `EFR_C_TWO_LO : `EFR_C_RD_LO);
        idx = off8[4:1];
        case (idx)
            `EFR_V_INPUT: var_val = {4'h0, in_val};
            `EFR_V_TARGET: var_val = {4'h0, target_o};
            `EFR_V_FB: var_val = {4'h0, fb_i};
            `EFR_V_SFB: var_val = scaled_fb_i;
            `EFR_V_SUM: var_val = err_sum_i;
            `EFR_V_DTGT: var_val = duty_tgt_i;
            `EFR_V_DUTY: var_val = duty_i;
            `EFR_V_CUR: var_val = {8'h00, current_i};
            `EFR_V_PID: var_val = pid_count_i;
            default: var_val = 16'h0000;
        endcase
        if (is_halt) begin
            var_val = halt & en_eff;
        end else if (is_occ) begin
            var_val = occ;
        end
        resp_hi = var_val[15:8];
        resp_lo = (!two && off8[0]) ? var_val[15:8] : var_val[7:0];
    end

    // ****************************************************************
    // Error word
    // ****************************************************************

    assign en_eff = (err_en_i | `EFR_AWAIT_MASK) & `EFR_RSV_MASK;
    assign halt_clr = ((go && is_halt) ? ~`EFR_AWAIT_MASK : 16'h0000)
                      | (set_tgt ? `EFR_AWAIT_MASK : 16'h0000);

    // Error events of this cycle
    always_comb begin
        ev = 16'h0000;
        ev[`EFR_B_AWAIT] = motor_off || (!por_done && input_mode_i == IN_SERIAL);
        ev[`EFR_B_NOPWR] = usb_i && !motor_pwr_i;
        ev[`EFR_B_DRV] = drv_fault_i || (usb_i && !motor_pwr_i);
        ev[`EFR_B_INVAL] = pw_invalid && input_mode_i == IN_PULSE;
        ev[`EFR_B_INDISC] = in_val > in_max_i || in_val < in_min_i
            || (aux_in_en_i && input_mode_i == IN_ANALOG && aux_in_open_i);
        ev[`EFR_B_FBDISC] = fb_i > fb_max_i || fb_i < fb_min_i
            || (aux_fb_en_i && fb_analog_i && aux_fb_open_i);
        ev[`EFR_B_CUR] = current_i > current_max_i;
        ev[`EFR_B_FRAME] = rx_frame_err_i;
        ev[`EFR_B_OVR] = rx_overrun_i;
        ev[`EFR_B_FULL] = rx_drop_i;
        ev[`EFR_B_CRC] = crc_bad;
        ev[`EFR_B_PROTO] = proto_bad;
        ev[`EFR_B_TMO] = tmo_en_i && tmo_ms_i != 16'h0000 && tmo_ms >= tmo_ms_i;
    end

    // Latched and sticky sets; a new event beats a clear in the same cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            halt <= 16'h0000;
            occ <= 16'h0000;
            por_done <= 1'b0;
        end else begin
            por_done <= 1'b1;
            halt <= (halt & ~halt_clr) | (ev & en_eff);
            occ <= ((go && is_occ) ? 16'h0000 : occ) | ev;
        end
    end

    // Error indication ignores the awaiting bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_line_o <= 1'b0;
            red_led_o <= 1'b0;
        end else begin
            err_line_o <= |(halt & en_eff & `EFR_STOP_MASK);
            red_led_o <= |(halt & en_eff & `EFR_STOP_MASK);
        end
    end

    // Timeout clock; any accepted command restarts it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ms_cnt <= 32'h0;
            tmo_ms <= 16'h0000;
        end else if (!tmo_en_i || go) begin
            ms_cnt <= 32'h0;
            tmo_ms <= 16'h0000;
        end else if (ms_cnt >= MS_CYC - 1) begin
            ms_cnt <= 32'h0;
            if (tmo_ms != 16'hffff) begin
                tmo_ms <= tmo_ms + 16'h0001;
            end
        end else begin
            ms_cnt <= ms_cnt + 32'h1;
        end
    end

    // Recovery: toggle the driver line periodically while the fault stands
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rec_cnt <= 32'h0;
            drv_toggle_o <= 1'b0;
        end else if (!ev[`EFR_B_DRV]) begin
            rec_cnt <= 32'h0;
            drv_toggle_o <= 1'b0;
        end else if (rec_cnt >= RECOV_CYC - 1) begin
            rec_cnt <= 32'h0;
            drv_toggle_o <= ~drv_toggle_o;
        end else begin
            rec_cnt <= rec_cnt + 32'h1;
        end
    end

    // ****************************************************************
    // Response sender
    // ****************************************************************

    // A read arriving while a reply is still pending is dropped
    assign tx_free = !tx_valid_o || (tx_ready_i && !pend);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_byte_o <= 8'h00;
            tx_valid_o <= 1'b0;
            pend <= 1'b0;
            pend_byte <= 8'h00;
        end else if (rd_go && tx_free) begin
            tx_byte_o <= resp_lo;
            tx_valid_o <= 1'b1;
            pend <= two;
            pend_byte <= resp_hi;
        end else if (tx_valid_o && tx_ready_i) begin
            if (pend) begin
                tx_byte_o <= pend_byte;
                pend <= 1'b0;
            end else begin
                tx_valid_o <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    reserved_zero_a: assert property (halt[15:13] == 3'h0 && occ[15:13] == 3'h0)
        else $error("reserved error bits set");
    stop_line_a: assert property (|(halt & en_eff & `EFR_STOP_MASK) |=> err_line_o && red_led_o)
        else $error("stopping error not indicated");
    over_current_a: assert property (current_i > current_max_i |=> occ[`EFR_B_CUR])
        else $error("over current not recorded");
    stop_bit_a: assert property (rx_frame_err_i |=> occ[`EFR_B_FRAME])
        else $error("missing stop bit not recorded");
    crc_drop_a: assert property ((rx_valid_i && st == ST_CRC && !rx_byte_i[7] && rx_byte_i != crc)
        |=> !go && crc_bad ##1 occ[`EFR_B_CRC])
        else $error("bad check byte not handled");
    bad_packet_a: assert property ((rx_valid_i && rx_byte_i[7] && st == ST_DATA)
        |=> proto_bad ##1 occ[`EFR_B_PROTO])
        else $error("interrupted packet not flagged");
    halt_clear_a: assert property ((go && is_halt && ev[12:1] == 12'h000)
        |=> halt[12:1] == 12'h000)
        else $error("halting read did not clear");
    target_await_a: assert property (set_tgt |=> !halt[`EFR_B_AWAIT])
        else $error("set target left awaiting bit");
    occ_clear_a: assert property ((go && is_occ && ev == 16'h0000) |=> occ == 16'h0000)
        else $error("occurred set not cleared");
    two_byte_a: assert property ((rd_go && tx_free && two)
        |=> tx_valid_o && tx_byte_o == $past(resp_lo) && pend && pend_byte == $past(resp_hi))
        else $error("two byte read order wrong");
endmodule : efr_readout
`default_nettype wire

//--- efr_map.svh
`ifndef EFR_MAP_SVH
`define EFR_MAP_SVH
// ****************************************************************
// ****************************************************************

// Error word bit positions
`define EFR_B_AWAIT 0
`define EFR_B_NOPWR 1
`define EFR_B_DRV 2
`define EFR_B_INVAL 3
`define EFR_B_INDISC 4
`define EFR_B_FBDISC 5
`define EFR_B_CUR 6
`define EFR_B_FRAME 7
`define EFR_B_OVR 8
`define EFR_B_FULL 9
`define EFR_B_CRC 10
`define EFR_B_PROTO 11
`define EFR_B_TMO 12
`define EFR_AWAIT_MASK 16'h0001
`define EFR_STOP_MASK 16'h1ffe
`define EFR_RSV_MASK 16'h1fff

// Command bytes
`define EFR_C_START 8'haa
`define EFR_C_HALT 8'hb3
`define EFR_C_OCC 8'hb5
`define EFR_C_OFF 8'hff
`define EFR_C_REV 8'he0
`define EFR_C_FWD 8'he1
`define EFR_C_HIRES 3'h6
`define EFR_C_RD_LO 8'h81
`define EFR_C_TWO_LO 8'ha1
`define EFR_C_RD_HI 8'hbf
`define EFR_CMD_MSB 8'h80
`define EFR_CRC_POLY 8'h91
`define EFR_LEN_BAD 2'h3
`define EFR_TGT_MID 12'h800

// Variable indexes
`define EFR_V_INPUT 4'h0
`define EFR_V_TARGET 4'h1
`define EFR_V_FB 4'h2
`define EFR_V_SFB 4'h3
`define EFR_V_SUM 4'h4
`define EFR_V_DTGT 4'h5
`define EFR_V_DUTY 4'h6
`define EFR_V_CUR 4'h7
`define EFR_V_PID 4'h8

// Timing
`define EFR_CLK_NS 10
`define EFR_NS_PER_MS 1000000
`define EFR_NS_PER_US 1000
`define EFR_IN_TMO_MS 120
`define EFR_RECOV_US 1000
`define EFR_RUN_NEED 3'h4
`endif

//--- efr_pkg.sv
`default_nettype none
package efr_pkg;
    // Input source selection
    typedef enum logic [1:0] {IN_ANALOG, IN_PULSE, IN_SERIAL} efr_inmode_e;
    // Packet parser states
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACMD, ST_DATA, ST_CRC, ST_SKIP} efr_state_e;
    typedef logic [15:0] efr_word_t;
endpackage : efr_pkg
`default_nettype wire

//--- efr_pulse_in.sv
`timescale 1ns/1ns
`default_nettype none
`include "efr_map.svh"
module efr_pulse_in #(
    parameter int unsigned TMO_CYC = `EFR_IN_TMO_MS * (`EFR_NS_PER_MS / `EFR_CLK_NS)
) (
    input wire logic clk_i, // System clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic enable_i, // Pulse-width input mode
    input wire logic pulse_done_i, // One pulse measured
    input wire logic pulse_good_i, // Measured pulse is valid
    input wire logic [11:0] pulse_width_i, // Measured width
    output logic [11:0] value_o, // Accepted input value
    output logic invalid_o // No update for too long
);
    import efr_pkg::*;

    logic [2:0] run;
    logic [31:0] idle;
    logic good;
    logic bad;
    logic upd;

    // Pulse qualification
    assign good = enable_i & pulse_done_i & pulse_good_i;
    assign bad = enable_i & pulse_done_i & ~pulse_good_i;
    assign upd = good && (run >= (`EFR_RUN_NEED - 3'h1));

    // Good pulses in a row; saturates so each later good pulse updates
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run <= 3'h0;
        end else if (bad || !enable_i) begin
            run <= 3'h0;
        end else if (good && run != `EFR_RUN_NEED) begin
            run <= run + 3'h1;
        end
    end

    // Accepted value
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_o <= 12'h000;
        end else if (upd) begin
            value_o <= pulse_width_i;
        end
    end

    // Staleness timer; saturates just past the limit to stay small in effect
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle <= 32'h0;
            invalid_o <= 1'b0;
        end else begin
            if (!enable_i || upd) begin
                idle <= 32'h0;
            end else if (idle <= TMO_CYC) begin
                idle <= idle + 32'h1;
            end
            invalid_o <= enable_i && (idle > TMO_CYC);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    early_pulse_a: assert property ((good && run < 3'h3) |=> value_o == $past(value_o))
        else $error("input updated before four good pulses");
    other_mode_a: assert property (!enable_i |=> !invalid_o)
        else $error("input invalid raised outside pulse mode");
endmodule : efr_pulse_in
`default_nettype wire

//--- efr_host.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Host side of the link
// ****
module efr_host (
    input wire logic clk_i, // System clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic slow_i, // Stall every other cycle
    input wire logic [7:0] tx_byte_i, // Response byte
    input wire logic tx_valid_i, // Response valid
    output logic tx_ready_o // Byte taken
);
    logic [7:0] got[$];
    // A byte counts only on an edge where valid and ready are both high
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_ready_o <= 1'b0;
        end else begin
            if (tx_valid_i && tx_ready_o) got.push_back(tx_byte_i);
            tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
        end
    end
endmodule : efr_host
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import efr_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, rx_valid_i, rx_frame_err_i, rx_overrun_i, rx_drop_i;
    logic crc_en_i, tmo_en_i, aux_in_en_i, aux_in_open_i, pulse_done_i, pulse_good_i, slow;
    logic fb_analog_i, aux_fb_en_i, aux_fb_open_i, drv_fault_i, usb_i, motor_pwr_i;
    logic tx_ready_i, tx_valid_o, err_line_o, red_led_o, drv_toggle_o;
    logic [6:0] dev_num_i;
    logic [7:0] rx_byte_i, current_i, current_max_i, tx_byte_o;
    logic [11:0] analog_in_i, in_max_i, in_min_i, pulse_width_i, fb_i, fb_max_i, fb_min_i;
    logic [11:0] target_o;
    logic [15:0] tmo_ms_i, scaled_fb_i, err_sum_i, duty_tgt_i, duty_i, pid_count_i;
    efr_inmode_e input_mode_i;
    efr_word_t err_en_i;
    int fail_count = 0, compares = 0;
    // Short counts keep the run brief
    efr_readout #(.IN_TMO_CYC(200), .MS_CYC(10), .RECOV_CYC(8)) dut_u (.*);
    efr_host host_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .tx_byte_i(tx_byte_o),
        .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));
    always #5 clk_i = ~clk_i;
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            $display("wrong value %s: expected %h, seen %h", nm, exp, got);
            fail_count++;
        end
    endtask : chk
    task automatic put(input logic [7:0] b);
        @(posedge clk_i);
        rx_valid_i <= 1'b1;
        rx_byte_i <= b;
    endtask : put
    // Each pulse is one measured, one-cycle completion strobe
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk_i);
            pulse_done_i <= 1'b1;
            @(posedge clk_i);
            pulse_done_i <= 1'b0;
        end
    endtask : pulse
    task automatic idle(input int n);
        @(posedge clk_i);
        rx_valid_i <= 1'b0;
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : idle
    // Wait, bounded, for n reply bytes and compare them low byte first
    task automatic get(input string nm, input int n, input logic [15:0] exp);
        int i;
        idle(0);
        for (i = 0; i < 200 && host_u.got.size() < n; i++) @(negedge clk_i);
        if (i == 200) begin
            fail_count++;
            finish_test();
        end else begin
            chk(nm, exp, n == 2 ? {host_u.got[1], host_u.got[0]} : {8'h00, host_u.got[0]});
            host_u.got.delete();
            $display("test %s done", nm);
        end
    endtask : get
    initial begin
        {rx_valid_i, rx_frame_err_i, rx_overrun_i, rx_drop_i, crc_en_i, tmo_en_i} = '0;
        {aux_in_en_i, aux_in_open_i, pulse_done_i, pulse_good_i, slow, fb_analog_i} = '0;
        {aux_fb_en_i, aux_fb_open_i, drv_fault_i, usb_i, rx_byte_i, analog_in_i} = '0;
        {in_min_i, pulse_width_i, fb_i, fb_min_i, tmo_ms_i, scaled_fb_i, err_sum_i} = '0;
        {in_max_i, fb_max_i} = '1;
        motor_pwr_i = 1'b1;
        dev_num_i = 7'h05;
        current_i = 8'h3c;
        current_max_i = 8'hff;
        duty_tgt_i = 16'h0000;
        duty_i = 16'hfffe;
        pid_count_i = 16'h1234;
        input_mode_i = IN_SERIAL;
        err_en_i = 16'hffff;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        put(8'hb5);
        get("occurred at start", 2, 16'h0001);
        put(8'hdd);
        put(8'h64);
        idle(3);
        chk("target", 16'h0c9d, {4'h0, target_o});
        put(8'ha3);
        get("target read", 2, 16'h0c9d);
        put(8'h84);
        get("target high", 1, 16'h000c);
        slow <= 1'b1;
        put(8'had);
        get("duty", 2, 16'hfffe);
        put(8'h8f);
        get("current", 1, 16'h003c);
        put(8'h92);
        get("period high", 1, 16'h0012);
        // Bit 8 disabled: it must stay out of the halting word
        err_en_i <= 16'hfeff;
        @(posedge clk_i);
        drv_fault_i <= 1'b1;
        rx_overrun_i <= 1'b1;
        rx_frame_err_i <= 1'b1;
        current_max_i <= 8'h3b;
        @(posedge clk_i);
        drv_fault_i <= 1'b0;
        rx_overrun_i <= 1'b0;
        rx_frame_err_i <= 1'b0;
        current_max_i <= 8'hff;
        idle(3);
        chk("error line", 16'h0001, {15'h0, err_line_o & red_led_o});
        put(8'haa);
        put(8'h05);
        put(8'h33);
        get("halting", 2, 16'h00c4);
        put(8'hb3);
        get("halting again", 2, 16'h0000);
        chk("error line clear", 16'h0000, {15'h0, err_line_o});
        // A standing driver fault flips the recovery line every 8 cycles
        drv_fault_i <= 1'b1;
        idle(10);
        chk("recovery toggle", 16'h0001, {15'h0, drv_toggle_o});
        drv_fault_i <= 1'b0;
        idle(1);
        chk("recovery idle", 16'h0000, {15'h0, drv_toggle_o});
        put(8'hb5);
        get("occurred events", 2, 16'h01c4);
        put(8'h80);
        idle(2);
        put(8'hb5);
        get("bad command", 2, 16'h0800);
        // A command byte cutting a packet short is flagged, yet still runs
        put(8'hc0);
        put(8'hb5);
        get("interrupted", 2, 16'h0000);
        put(8'hb5);
        get("interrupted flag", 2, 16'h0800);
        crc_en_i <= 1'b1;
        put(8'hb5);
        put(8'h35);
        idle(2);
        put(8'hb5);
        put(8'h34);
        get("check byte", 2, 16'h0400);
        crc_en_i <= 1'b0;
        input_mode_i <= IN_PULSE;
        pulse_good_i <= 1'b1;
        pulse_width_i <= 12'h123;
        pulse(3);
        put(8'ha1);
        get("pulse early", 2, 16'h0000);
        pulse(1);
        put(8'ha1);
        get("pulse input", 2, 16'h0123);
        idle(250);
        put(8'hb5);
        get("input stale", 2, 16'h0008);
        input_mode_i <= IN_ANALOG;
        analog_in_i <= 12'hffc;
        put(8'ha1);
        get("analog input", 2, 16'h0ffc);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
